//--- include/gt_defs.svh
// register offsets, field positions, reset values and timing counts
`ifndef GT_DEFS_SVH
`define GT_DEFS_SVH

`define GT_A_CFG 5'h00
`define GT_A_SCALE 5'h01
`define GT_A_DSG_THR 5'h02
`define GT_A_CHG_THR 5'h03
`define GT_A_QUIT 5'h04
`define GT_A_DSG_RLX 5'h05
`define GT_A_CHG_RLX 5'h06
`define GT_A_QUIT_RLX 5'h07
`define GT_A_RES_CAP 5'h08
`define GT_A_RES_EN 5'h09
`define GT_A_DES_CAP 5'h0A
`define GT_A_DES_EN 5'h0B
`define GT_A_T_RISE 5'h0C
`define GT_A_CAP_STEP 5'h0D
`define GT_A_RA_STEP 5'h0E
`define GT_A_RA_FLOOR 5'h0F
`define GT_A_RA_CEIL 5'h10
`define GT_A_DV_MAX 5'h11
`define GT_A_DV_MIN 5'h12
`define GT_A_GRID_LIM 5'h13
`define GT_A_TERM_V 5'h14
`define GT_A_TERM_DV 5'h15
`define GT_A_FAST_SOC 5'h16
`define GT_A_QMAX 5'h17
`define GT_A_LEARN 5'h18
`define GT_A_AVG_I 5'h19
`define GT_A_AVG_P 5'h1A
`define GT_A_DELTA_V 5'h1B
`define GT_A_STATUS 5'h1C
`define GT_A_RA_SEL 5'h1D
`define GT_A_RA_DATA 5'h1E
`define GT_CFG_WORDS 23

`define GT_CFG_LOAD_MODE 0
`define GT_CFG_RES_SEL 1
`define GT_CFG_FAST_EN 2
`define GT_CFG_SMOOTH_EN 3

`define GT_ST_DSG 0
`define GT_ST_CHG 1
`define GT_ST_RELAX 2
`define GT_ST_OCV 3
`define GT_ST_QMAX_OK 4
`define GT_ST_FAST 5

`define GT_SCALE_FINE 16'h0001
`define GT_SCALE_COARSE 16'h000A

`define GT_LS_GOLDEN 8'h02
`define GT_LS_ENABLED 8'h04
`define GT_LS_QMAX 8'h05
`define GT_LS_FULL 8'h06

`define GT_RST_CFG 16'h0000
`define GT_RST_DSG_THR 16'h003C
`define GT_RST_CHG_THR 16'h004B
`define GT_RST_QUIT 16'h0028
`define GT_RST_DSG_RLX 16'h003C
`define GT_RST_CHG_RLX 16'h003C
`define GT_RST_QUIT_RLX 16'h0001
`define GT_RST_CAP 16'h03E8
`define GT_RST_CAP_STEP 16'h0014
`define GT_RST_RA_STEP 16'h0064
`define GT_RST_RA_FLOOR 16'h0032
`define GT_RST_RA_CEIL 16'h00C8
`define GT_RST_DV_MAX 16'hFFFF
`define GT_RST_GRID_LIM 16'h0004
`define GT_RST_TERM_V 16'h0BB8
`define GT_RST_TERM_DV 16'h00C8
`define GT_RST_FAST_SOC 16'h000A
`define GT_RST_RA 16'h0064

`define GT_PCT 100
`define GT_UW_PER_MW 1000
`define GT_DVDT_LIMIT_UV 1
`define GT_CLK_HZ 10000000
`define GT_TICK_S 1
`define GT_SEC_CYCLES (`GT_CLK_HZ * `GT_TICK_S)
`define GT_OCV_WAIT_MIN 6
`define GT_OCV_WAIT_S (`GT_OCV_WAIT_MIN * 60)

`endif

//--- include/gt_pkg.sv
// types shared by the gauge tuning block
package gt_pkg;
  typedef enum logic [1:0] {
    st_active = 2'b01,
    st_relax = 2'b10
  } gt_relax_e;
  typedef logic [15:0] gt_word_t;
endpackage : gt_pkg

//--- core/gt_core.sv
// gauge tuning parameters, rest detection and learning bookkeeping
// Notes on behaviour
// - energy scale accepts only one or ten
// - coarse scale multiplies energy and temperature rise, divides power
// - current mode applies reserve capacity, selectable compensation
// - power mode applies reserve energy amount
// - discharging when magnitude exceeds discharge threshold
// - charging when magnitude exceeds charge threshold
// - enter rest after quiet for relax time
// - open-circuit readings after six minutes rest
// - capacity update needs slope below 1 uV/s
// - leave rest after quit relax time
// - learning status encodes four states
// - only device changes learning status
// - log average current of each discharge
// - power is current times voltage, averaged
// - record largest spike voltage difference
// - resistance step and cumulative factor limits
// - capacity change clamped to step percentage
// - delta voltage clamped between limits
// - no back scaling beyond grid limit
// - fast scaling starts on voltage or percent
// - smoothing off reports unfiltered values
// - load mode one selects power model
`include "gt_defs.svh"

module gt_core #(
  parameter int SEC_CYCLES = `GT_SEC_CYCLES,
  parameter int RA_N = 15
) (
  input logic clk,
  input logic nrst,
  input logic [4:0] addr,
  input logic [15:0] wdata,
  input logic wr_stb,
  input logic rd_stb,
  output logic [15:0] rdata,
  input logic meas_valid,
  input logic signed [15:0] inst_current,
  input logic signed [15:0] average_current_value,
  input logic [15:0] cell_voltage,
  input logic signed [15:0] dvdt_uvps,
  input logic [15:0] spike_dv,
  input logic [15:0] raw_remaining_capacity,
  input logic [15:0] raw_full_capacity,
  input logic [15:0] filt_remaining_capacity,
  input logic [15:0] filt_full_capacity,
  input logic tracking_enable_cmd,
  input logic qmax_req,
  input logic [15:0] qmax_proposed,
  input logic ra_req,
  input logic [3:0] ra_grid,
  input logic [15:0] ra_proposed,
  input logic ra_backscale,
  output logic discharging,
  output logic charging,
  output logic relax_state,
  output logic ocv_enable,
  output logic qmax_update_ok,
  output logic fast_scale_active,
  output logic reserve_loaded_rate,
  output logic [19:0] reserve_amount,
  output logic [19:0] design_energy_eff,
  output logic [19:0] t_rise_eff,
  output logic [15:0] remaining_capacity_value,
  output logic [15:0] full_capacity_value,
  output logic [7:0] charge_percent_value,
  output logic [15:0] delta_v,
  output logic [15:0] qmax
);

  gt_pkg::gt_word_t cfg_mem [0:`GT_CFG_WORDS-1];
  gt_pkg::gt_word_t ra_tab [0:RA_N-1];
  gt_pkg::gt_word_t ra_base [0:RA_N-1];
  gt_pkg::gt_relax_e state_reg;
  logic [31:0] div_cnt_reg;
  logic sec_tick_reg;
  logic [15:0] relax_cnt_reg;
  logic [15:0] rest_sec_reg;
  logic [7:0] learn_reg;
  logic [39:0] isum_reg;
  logic [47:0] psum_reg;
  logic [23:0] n_reg;
  logic [15:0] avg_i_reg;
  logic [15:0] avg_p_reg;
  logic [3:0] ra_sel_reg;
  logic dsg_prev_reg;
  logic [15:0] cur_abs;
  logic [15:0] avg_abs;
  logic [15:0] scale;
  logic [15:0] pw;
  logic [31:0] qstep;
  logic [31:0] qmax_next;
  logic [31:0] ra_old;
  logic [31:0] ra_cur_base;
  logic [31:0] ra_next;
  logic [15:0] dv_cand;
  logic [15:0] rm_sel;
  logic [15:0] fcc_sel;
  logic [31:0] soc_calc;
  logic tracking_on;
  logic qmax_take;
  logic ra_take;
  logic cycle_start;

  function automatic logic [15:0] gt_abs(input logic signed [15:0] v);
    gt_abs = v[15] ? 16'(-v) : 16'(v);
  endfunction : gt_abs

  function automatic logic [31:0] gt_clamp(input logic [31:0] v,
    input logic [31:0] lo, input logic [31:0] hi);
    if (v < lo)
    begin
      gt_clamp = lo;
    end
    else if (v > hi)
    begin
      gt_clamp = hi;
    end
    else
    begin
      gt_clamp = v;
    end
  endfunction : gt_clamp

  function automatic logic [15:0] gt_rst(input logic [4:0] a);
    case (a)
      `GT_A_SCALE: gt_rst = `GT_SCALE_FINE;
      `GT_A_DSG_THR: gt_rst = `GT_RST_DSG_THR;
      `GT_A_CHG_THR: gt_rst = `GT_RST_CHG_THR;
      `GT_A_QUIT: gt_rst = `GT_RST_QUIT;
      `GT_A_DSG_RLX: gt_rst = `GT_RST_DSG_RLX;
      `GT_A_CHG_RLX: gt_rst = `GT_RST_CHG_RLX;
      `GT_A_QUIT_RLX: gt_rst = `GT_RST_QUIT_RLX;
      `GT_A_DES_CAP: gt_rst = `GT_RST_CAP;
      `GT_A_CAP_STEP: gt_rst = `GT_RST_CAP_STEP;
      `GT_A_RA_STEP: gt_rst = `GT_RST_RA_STEP;
      `GT_A_RA_FLOOR: gt_rst = `GT_RST_RA_FLOOR;
      `GT_A_RA_CEIL: gt_rst = `GT_RST_RA_CEIL;
      `GT_A_DV_MAX: gt_rst = `GT_RST_DV_MAX;
      `GT_A_GRID_LIM: gt_rst = `GT_RST_GRID_LIM;
      `GT_A_TERM_V: gt_rst = `GT_RST_TERM_V;
      `GT_A_TERM_DV: gt_rst = `GT_RST_TERM_DV;
      `GT_A_FAST_SOC: gt_rst = `GT_RST_FAST_SOC;
      default: gt_rst = `GT_RST_CFG;
    endcase
  endfunction : gt_rst

  assign scale = cfg_mem[`GT_A_SCALE];
  assign cur_abs = gt_abs(inst_current);
  assign avg_abs = gt_abs(average_current_value);
  assign tracking_on = (learn_reg != `GT_LS_GOLDEN);
  assign cycle_start = discharging && !dsg_prev_reg;
  // mA times mV gives uW; the coarse scale turns mW into cW
  assign pw = 16'((32'(cur_abs) * 32'(cell_voltage))
    / (32'(`GT_UW_PER_MW) * 32'(scale)));

  // configuration words; out-of-set scale writes are dropped
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < `GT_CFG_WORDS; i++)
      begin
        cfg_mem[i] <= gt_rst(5'(i));
      end
    end
    else if (wr_stb && addr < 5'(`GT_CFG_WORDS))
    begin
      if (addr != `GT_A_SCALE || wdata == `GT_SCALE_FINE ||
          wdata == `GT_SCALE_COARSE)
      begin
        cfg_mem[addr] <= wdata;
      end
    end
  end

  // one-second enable for all relax timing
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      div_cnt_reg <= 32'h0000_0000;
      sec_tick_reg <= 1'b0;
    end
    else if (div_cnt_reg >= 32'(SEC_CYCLES - 1))
    begin
      div_cnt_reg <= 32'h0000_0000;
      sec_tick_reg <= 1'b1;
    end
    else
    begin
      div_cnt_reg <= div_cnt_reg + 32'h0000_0001;
      sec_tick_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      discharging <= 1'b0;
      charging <= 1'b0;
      dsg_prev_reg <= 1'b0;
    end
    else
    begin
      discharging <= inst_current[15] &&
        (cur_abs > cfg_mem[`GT_A_DSG_THR]);
      charging <= !inst_current[15] &&
        (cur_abs > cfg_mem[`GT_A_CHG_THR]);
      dsg_prev_reg <= discharging;
    end
  end

  // the quiet-time counter restarts on any excursion
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      state_reg <= gt_pkg::st_active;
      relax_cnt_reg <= 16'h0000;
    end
    else
    begin
      unique case (state_reg)
        gt_pkg::st_active:
        begin
          if (avg_abs >= cfg_mem[`GT_A_QUIT])
          begin
            relax_cnt_reg <= 16'h0000;
          end
          // strict compare, so a partial first second never counts
          else if (relax_cnt_reg > cfg_mem[`GT_A_DSG_RLX] ||
                   relax_cnt_reg > cfg_mem[`GT_A_CHG_RLX])
          begin
            state_reg <= gt_pkg::st_relax;
            relax_cnt_reg <= 16'h0000;
          end
          else if (sec_tick_reg && relax_cnt_reg != 16'hFFFF)
          begin
            relax_cnt_reg <= relax_cnt_reg + 16'h0001;
          end
        end
        gt_pkg::st_relax:
        begin
          if (avg_abs <= cfg_mem[`GT_A_QUIT])
          begin
            relax_cnt_reg <= 16'h0000;
          end
          else if (relax_cnt_reg > cfg_mem[`GT_A_QUIT_RLX])
          begin
            state_reg <= gt_pkg::st_active;
            relax_cnt_reg <= 16'h0000;
          end
          else if (sec_tick_reg && relax_cnt_reg != 16'hFFFF)
          begin
            relax_cnt_reg <= relax_cnt_reg + 16'h0001;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      rest_sec_reg <= 16'h0000;
      relax_state <= 1'b0;
      ocv_enable <= 1'b0;
      qmax_update_ok <= 1'b0;
    end
    else
    begin
      relax_state <= (state_reg == gt_pkg::st_relax);
      if (state_reg != gt_pkg::st_relax)
      begin
        rest_sec_reg <= 16'h0000;
      end
      else if (sec_tick_reg && rest_sec_reg < 16'(`GT_OCV_WAIT_S))
      begin
        rest_sec_reg <= rest_sec_reg + 16'h0001;
      end
      ocv_enable <= (state_reg == gt_pkg::st_relax) &&
        (rest_sec_reg >= 16'(`GT_OCV_WAIT_S));
      qmax_update_ok <= (state_reg == gt_pkg::st_relax) &&
        (rest_sec_reg >= 16'(`GT_OCV_WAIT_S)) &&
        (gt_abs(dvdt_uvps) < 16'(`GT_DVDT_LIMIT_UV));
    end
  end

  // per-cycle sums; the division happens once, at cycle end
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      isum_reg <= 40'h00_0000_0000;
      psum_reg <= 48'h0000_0000_0000;
      n_reg <= 24'h00_0000;
      avg_i_reg <= 16'h0000;
      avg_p_reg <= 16'h0000;
    end
    else if (dsg_prev_reg && !discharging)
    begin
      if (n_reg != 24'h00_0000)
      begin
        avg_i_reg <= 16'(isum_reg / 40'(n_reg));
        avg_p_reg <= 16'(psum_reg / 48'(n_reg));
      end
      isum_reg <= 40'h00_0000_0000;
      psum_reg <= 48'h0000_0000_0000;
      n_reg <= 24'h00_0000;
    end
    else if (meas_valid && discharging && n_reg != 24'hFF_FFFF)
    begin
      isum_reg <= isum_reg + 40'(cur_abs);
      psum_reg <= psum_reg + 48'(pw);
      n_reg <= n_reg + 24'h00_0001;
    end
  end

  always_comb
  begin
    dv_cand = (spike_dv > delta_v) ? spike_dv : delta_v;
    dv_cand = 16'(gt_clamp(32'(dv_cand), 32'(cfg_mem[`GT_A_DV_MIN]),
      32'(cfg_mem[`GT_A_DV_MAX])));
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      delta_v <= 16'h0000;
    end
    else if (meas_valid)
    begin
      delta_v <= dv_cand;
    end
  end

  always_comb
  begin
    qstep = (32'(cfg_mem[`GT_A_DES_CAP]) * 32'(cfg_mem[`GT_A_CAP_STEP]))
      / 32'(`GT_PCT);
    qmax_next = gt_clamp(32'(qmax_proposed),
      (qstep > 32'(qmax)) ? 32'h0000_0000 : 32'(qmax) - qstep,
      32'(qmax) + qstep);
    if (qmax_next > 32'h0000_FFFF)
    begin
      qmax_next = 32'h0000_FFFF;
    end
  end

  assign qmax_take = qmax_req && qmax_update_ok && tracking_on;

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      qmax <= `GT_RST_CAP;
    end
    else if (qmax_take)
    begin
      qmax <= 16'(qmax_next);
    end
    else if (wr_stb && addr == `GT_A_QMAX)
    begin
      qmax <= wdata;
    end
  end

  always_comb
  begin
    ra_old = 32'h0000_0000;
    ra_cur_base = 32'h0000_0000;
    if (32'(ra_grid) < 32'(RA_N))
    begin
      ra_old = 32'(ra_tab[ra_grid]);
      ra_cur_base = 32'(ra_base[ra_grid]);
    end
    ra_next = gt_clamp(32'(ra_proposed),
      (32'(cfg_mem[`GT_A_RA_STEP]) > ra_old) ? 32'h0000_0000 :
      ra_old - 32'(cfg_mem[`GT_A_RA_STEP]),
      ra_old + 32'(cfg_mem[`GT_A_RA_STEP]));
    ra_next = gt_clamp(ra_next,
      ra_cur_base * 32'(cfg_mem[`GT_A_RA_FLOOR]) / 32'(`GT_PCT),
      ra_cur_base * 32'(cfg_mem[`GT_A_RA_CEIL]) / 32'(`GT_PCT));
    if (ra_next > 32'h0000_FFFF)
    begin
      ra_next = 32'h0000_FFFF;
    end
  end

  // back scaling past the limit grid point is simply refused
  assign ra_take = ra_req && tracking_on && 32'(ra_grid) < 32'(RA_N) &&
    !(ra_backscale &&
      16'(ra_grid) > cfg_mem[`GT_A_GRID_LIM]);

  generate
    for (genvar g = 0; g < RA_N; g++)
    begin : g_ra
      always_ff @(posedge clk)
      begin
        if (!nrst)
        begin
          ra_tab[g] <= `GT_RST_RA;
          ra_base[g] <= `GT_RST_RA;
        end
        else
        begin
          if (cycle_start)
          begin
            ra_base[g] <= ra_tab[g];
          end
          if (ra_take && ra_grid == 4'(g))
          begin
            ra_tab[g] <= 16'(ra_next);
          end
          else if (wr_stb && addr == `GT_A_RA_DATA &&
                   ra_sel_reg == 4'(g))
          begin
            ra_tab[g] <= wdata;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      ra_sel_reg <= 4'h0;
    end
    else if (wr_stb && addr == `GT_A_RA_SEL)
    begin
      ra_sel_reg <= wdata[3:0];
    end
  end

  // software writes to the status word have no effect
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      learn_reg <= `GT_LS_GOLDEN;
    end
    else if (tracking_enable_cmd)
    begin
      learn_reg <= `GT_LS_ENABLED;
    end
    else if (qmax_take && learn_reg == `GT_LS_ENABLED)
    begin
      learn_reg <= `GT_LS_QMAX;
    end
    else if (ra_take && learn_reg == `GT_LS_QMAX)
    begin
      learn_reg <= `GT_LS_FULL;
    end
  end

  always_comb
  begin
    rm_sel = cfg_mem[`GT_A_CFG][`GT_CFG_SMOOTH_EN] ?
      filt_remaining_capacity : raw_remaining_capacity;
    fcc_sel = cfg_mem[`GT_A_CFG][`GT_CFG_SMOOTH_EN] ?
      filt_full_capacity : raw_full_capacity;
    soc_calc = (fcc_sel == 16'h0000) ? 32'h0000_0000 :
      (32'(rm_sel) * 32'(`GT_PCT)) / 32'(fcc_sel);
    if (soc_calc > 32'(`GT_PCT))
    begin
      soc_calc = 32'(`GT_PCT);
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      remaining_capacity_value <= 16'h0000;
      full_capacity_value <= 16'h0000;
      charge_percent_value <= 8'h00;
      fast_scale_active <= 1'b0;
    end
    else
    begin
      remaining_capacity_value <= rm_sel;
      full_capacity_value <= fcc_sel;
      charge_percent_value <= 8'(soc_calc);
      fast_scale_active <= cfg_mem[`GT_A_CFG][`GT_CFG_FAST_EN] &&
        ((17'(cell_voltage) < 17'(cfg_mem[`GT_A_TERM_V]) +
          17'(cfg_mem[`GT_A_TERM_DV])) ||
         (16'(charge_percent_value) <
          cfg_mem[`GT_A_FAST_SOC]));
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      reserve_loaded_rate <= 1'b0;
      reserve_amount <= 20'h0_0000;
      design_energy_eff <= 20'h0_0000;
      t_rise_eff <= 20'h0_0000;
    end
    else
    begin
      reserve_loaded_rate <= cfg_mem[`GT_A_CFG][`GT_CFG_RES_SEL];
      reserve_amount <= cfg_mem[`GT_A_CFG][`GT_CFG_LOAD_MODE] ?
        20'(32'(cfg_mem[`GT_A_RES_EN]) * 32'(scale)) :
        20'(cfg_mem[`GT_A_RES_CAP]);
      design_energy_eff <=
        20'(32'(cfg_mem[`GT_A_DES_EN]) * 32'(scale));
      t_rise_eff <=
        20'(32'(cfg_mem[`GT_A_T_RISE]) * 32'(scale));
    end
  end

  // read data stand one cycle behind the strobe, for as many cycles as it is held
  always_ff @(posedge clk)
  begin
    if (!nrst || !rd_stb)
    begin
      rdata <= 16'h0000;
    end
    else if (addr < 5'(`GT_CFG_WORDS))
    begin
      rdata <= cfg_mem[addr];
    end
    else
    begin
      case (addr)
        `GT_A_QMAX: rdata <= qmax;
        `GT_A_LEARN: rdata <= 16'(learn_reg);
        `GT_A_AVG_I: rdata <= avg_i_reg;
        `GT_A_AVG_P: rdata <= avg_p_reg;
        `GT_A_DELTA_V: rdata <= delta_v;
        `GT_A_STATUS: rdata <= {10'h000, fast_scale_active,
          qmax_update_ok, ocv_enable, relax_state, charging, discharging};
        `GT_A_RA_SEL: rdata <= 16'(ra_sel_reg);
        `GT_A_RA_DATA: rdata <= (32'(ra_sel_reg) < 32'(RA_N)) ?
          ra_tab[ra_sel_reg] : 16'h0000;
        default: rdata <= 16'h0000;
      endcase
    end
  end

endmodule : gt_core

//--- tb/gt_core_sva.sv
// port-level checker for the gauge tuning block
`include "gt_defs.svh"

module gt_core_sva (
  input logic clk,
  input logic nrst,
  input logic [4:0] addr,
  input logic wr_stb,
  input logic rd_stb,
  input logic [15:0] rdata,
  input logic qmax_req,
  input logic signed [15:0] dvdt_uvps,
  input logic [15:0] raw_remaining_capacity,
  input logic [15:0] filt_remaining_capacity,
  input logic discharging,
  input logic charging,
  input logic relax_state,
  input logic ocv_enable,
  input logic qmax_update_ok,
  input logic [15:0] remaining_capacity_value,
  input logic [7:0] charge_percent_value,
  input logic [15:0] qmax
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  a_dir_exclusive: assert property (!(discharging && charging))
    else $error("discharging and charging together");
  a_pct_ceiling: assert property (charge_percent_value <= 8'h64)
    else $error("charge percent above full");
  a_rdata_idle: assert property ($past(nrst) && !$past(rd_stb)
    |-> rdata == 16'h0000) else $error("read data outside read slot");
  a_learn_code: assert property ($past(rd_stb && addr == `GT_A_LEARN)
    |-> rdata inside {16'h0002, 16'h0004, 16'h0005, 16'h0006})
    else $error("learning status code not legal");
  a_ocv_in_rest: assert property (ocv_enable
    |-> relax_state || $past(relax_state))
    else $error("open-circuit readings outside rest");
  a_qok_slope: assert property (qmax_update_ok
    |-> $past(dvdt_uvps) == 16'sh0000)
    else $error("capacity update allowed with slope");
  a_qmax_cause: assert property ($past(nrst) && $changed(qmax)
    |-> $past(qmax_req && qmax_update_ok)
    || $past(wr_stb && addr == `GT_A_QMAX))
    else $error("capacity changed without a cause");
  a_rm_select: assert property ($past(nrst)
    |-> remaining_capacity_value == $past(raw_remaining_capacity)
    || remaining_capacity_value == $past(filt_remaining_capacity))
    else $error("remaining capacity not from a source");

  c_rest: cover property ($rose(relax_state));
  c_ocv: cover property ($rose(ocv_enable));
  c_qmax: cover property ($changed(qmax));
  c_dsg: cover property ($rose(discharging));
endmodule : gt_core_sva

bind gt_core gt_core_sva u_sva (.clk(clk), .nrst(nrst), .addr(addr),
  .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .qmax_req(qmax_req),
  .dvdt_uvps(dvdt_uvps), .raw_remaining_capacity(raw_remaining_capacity),
  .filt_remaining_capacity(filt_remaining_capacity),
  .discharging(discharging), .charging(charging),
  .relax_state(relax_state), .ocv_enable(ocv_enable),
  .qmax_update_ok(qmax_update_ok),
  .remaining_capacity_value(remaining_capacity_value),
  .charge_percent_value(charge_percent_value), .qmax(qmax));

//--- tb/gt_core_tb.sv
// self-checking bench for the gauge tuning block
`include "gt_defs.svh"

module gt_core_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [4:0] a;
    logic wr;
    logic [15:0] d;
    logic [15:0] e;
  } gt_row_s;
  logic clk = 1'b0, nrst = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0;
  logic [4:0] addr = 5'h00;
  logic [15:0] wdata = 16'h0000, rdata, cell_voltage = 16'h0E74;
  logic signed [15:0] inst_current = 16'sh0064, dvdt_uvps = 16'sh0000;
  logic signed [15:0] average_current_value = 16'sh0064;
  logic meas_valid = 1'b0, tracking_enable_cmd = 1'b0, qmax_req = 1'b0;
  logic ra_req = 1'b0, ra_backscale = 1'b0;
  logic [3:0] ra_grid = 4'h0;
  logic [15:0] ra_proposed = 16'h0000;
  logic [15:0] spike_dv = 16'h0000, qmax_proposed = 16'h0000;
  logic [15:0] raw_remaining_capacity = 16'h0032;
  logic [15:0] raw_full_capacity = 16'h00C8;
  logic [15:0] filt_remaining_capacity = 16'h0050;
  logic [15:0] filt_full_capacity = 16'h00A0;
  logic discharging, charging, relax_state, ocv_enable, qmax_update_ok;
  logic fast_scale_active, reserve_loaded_rate;
  logic [19:0] reserve_amount, design_energy_eff, t_rise_eff;
  logic [15:0] remaining_capacity_value, full_capacity_value, delta_v, qmax;
  logic [7:0] charge_percent_value;
  int miscompares = 0, comparisons = 0;
  gt_row_s rows [0:9] = '{
    '{`GT_A_DSG_THR, 1'b0, 16'h0000, `GT_RST_DSG_THR},
    '{`GT_A_CHG_THR, 1'b0, 16'h0000, `GT_RST_CHG_THR},
    '{`GT_A_QMAX, 1'b0, 16'h0000, `GT_RST_CAP},
    '{`GT_A_LEARN, 1'b0, 16'h0000, `GT_LS_GOLDEN},
    '{`GT_A_SCALE, 1'b1, `GT_SCALE_COARSE, `GT_SCALE_COARSE},
    '{`GT_A_SCALE, 1'b1, 16'h0005, `GT_SCALE_COARSE},
    '{`GT_A_LEARN, 1'b1, 16'h0006, `GT_LS_GOLDEN},
    '{5'h1F, 1'b1, 16'h1234, 16'h0000},
    '{`GT_A_DSG_RLX, 1'b1, 16'h0005, 16'h0005},
    '{`GT_A_CHG_RLX, 1'b1, 16'h0005, 16'h0005}
  };

  gt_core #(.SEC_CYCLES(10)) u_dut (.clk, .nrst, .addr, .wdata, .wr_stb,
    .rd_stb, .rdata, .meas_valid, .inst_current, .average_current_value,
    .cell_voltage, .dvdt_uvps, .spike_dv, .raw_remaining_capacity,
    .raw_full_capacity, .filt_remaining_capacity, .filt_full_capacity,
    .tracking_enable_cmd, .qmax_req, .qmax_proposed, .ra_req, .ra_grid,
    .ra_proposed, .ra_backscale,
    .discharging, .charging, .relax_state, .ocv_enable, .qmax_update_ok,
    .fast_scale_active, .reserve_loaded_rate, .reserve_amount,
    .design_energy_eff, .t_rise_eff, .remaining_capacity_value,
    .full_capacity_value, .charge_percent_value, .delta_v, .qmax);

  initial
  begin
    forever #50 clk = ~clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic chk(input string n, input logic [19:0] e,
    input logic [19:0] g);
    comparisons++;
    if (g !== e)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    wr_stb <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask : wr

  task automatic rdchk(input string n, input logic [4:0] a,
    input logic [15:0] e);
    @(posedge clk);
    rd_stb <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1;
    chk(n, {4'h0, e}, {4'h0, rdata});
  endtask : rdchk

  task automatic setcur(input logic [15:0] v);
    inst_current <= v;
    average_current_value <= v;
    cyc(3);
  endtask : setcur

  task automatic qupd(input logic [15:0] v);
    @(posedge clk);
    qmax_req <= 1'b1;
    qmax_proposed <= v;
    @(posedge clk);
    qmax_req <= 1'b0;
    cyc(2);
  endtask : qupd

  task automatic raupd(input logic [3:0] g, input logic [15:0] v,
    input logic b);
    @(posedge clk);
    ra_req <= 1'b1;
    ra_grid <= g;
    ra_proposed <= v;
    ra_backscale <= b;
    @(posedge clk);
    ra_req <= 1'b0;
    cyc(1);
  endtask : raupd

  task automatic results();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results

  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares++;
    results();
  end

  initial
  begin
    cyc(20);
    nrst <= 1'b1;
    cyc(1);
    foreach (rows[i])
    begin
      if (rows[i].wr)
        wr(rows[i].a, rows[i].d);
      rdchk("register", rows[i].a, rows[i].e);
    end
    wr(`GT_A_DES_EN, 16'h0064);
    wr(`GT_A_T_RISE, 16'h0007);
    wr(`GT_A_RES_EN, 16'h0005);
    wr(`GT_A_RES_CAP, 16'h001E);
    wr(`GT_A_CFG, 16'h0003);
    cyc(3);
    chk("energy", 20'h003E8, design_energy_eff);
    chk("trise", 20'h00046, t_rise_eff);
    chk("reserve", 20'h00032, reserve_amount);
    chk("loaded", 20'h00001, {19'h0, reserve_loaded_rate});
    wr(`GT_A_CFG, 16'h0000);
    wr(`GT_A_SCALE, `GT_SCALE_FINE);
    cyc(3);
    chk("reserve", 20'h0001E, reserve_amount);
    setcur(16'hFFC3);
    chk("dsg", 20'h1, {19'h0, discharging});
    setcur(16'hFFC4);
    chk("dsg", 20'h0, {19'h0, discharging});
    setcur(16'h004C);
    chk("chg", 20'h1, {19'h0, charging});
    setcur(16'h004B);
    chk("chg", 20'h0, {19'h0, charging});
    setcur(16'hFF9C);
    for (int i = 0; i < 4; i++)
    begin
      meas_valid <= 1'b1;
      spike_dv <= (i == 1) ? 16'h001E : 16'h0014;
      cyc(1);
      meas_valid <= 1'b0;
      cyc(1);
    end
    setcur(16'h0000);
    rdchk("avg_i", `GT_A_AVG_I, 16'h0064);
    rdchk("avg_p", `GT_A_AVG_P, 16'h0172);
    rdchk("dv", `GT_A_DELTA_V, 16'h001E);
    wr(`GT_A_DV_MAX, 16'h0019);
    meas_valid <= 1'b1;
    cyc(1);
    meas_valid <= 1'b0;
    cyc(2);
    chk("dv_clamp", 20'h00019, {4'h0, delta_v});
    setcur(16'h0064);
    setcur(16'h0000);
    cyc(32);
    chk("rest_early", 20'h0, {19'h0, relax_state});
    cyc(30);
    chk("rest", 20'h1, {19'h0, relax_state});
    cyc(3300);
    chk("ocv_early", 20'h0, {19'h0, ocv_enable});
    cyc(500);
    chk("ocv", 20'h1, {19'h0, ocv_enable});
    chk("qok", 20'h1, {19'h0, qmax_update_ok});
    dvdt_uvps <= 16'sh0001;
    cyc(2);
    chk("qok_slope", 20'h0, {19'h0, qmax_update_ok});
    dvdt_uvps <= 16'sh0000;
    cyc(2);
    qupd(16'h05DC);
    chk("qmax_golden", 20'h003E8, {4'h0, qmax});
    tracking_enable_cmd <= 1'b1;
    cyc(1);
    tracking_enable_cmd <= 1'b0;
    rdchk("learn", `GT_A_LEARN, `GT_LS_ENABLED);
    qupd(16'h05DC);
    chk("qmax_clamp", 20'h004B0, {4'h0, qmax});
    rdchk("learn", `GT_A_LEARN, `GT_LS_QMAX);
    qupd(16'h0384);
    chk("qmax_floor", 20'h003E8, {4'h0, qmax});
    qupd(16'h041A);
    chk("qmax_step", 20'h0041A, {4'h0, qmax});
    raupd(4'h1, 16'h000A, 1'b0);
    wr(`GT_A_RA_STEP, 16'h0014);
    raupd(4'h0, 16'h012C, 1'b0);
    raupd(4'h5, 16'h0078, 1'b1);
    rdchk("learn", `GT_A_LEARN, `GT_LS_FULL);
    wr(`GT_A_RA_SEL, 16'h0001);
    rdchk("ra_floor", `GT_A_RA_DATA, 16'h0032);
    wr(`GT_A_RA_SEL, 16'h0000);
    rdchk("ra_step", `GT_A_RA_DATA, 16'h0078);
    wr(`GT_A_RA_SEL, 16'h0005);
    rdchk("ra_grid", `GT_A_RA_DATA, 16'h0064);
    setcur(16'h0064);
    setcur(16'h0000);
    chk("rest_hold", 20'h1, {19'h0, relax_state});
    setcur(16'h0064);
    cyc(40);
    chk("rest_exit", 20'h0, {19'h0, relax_state});
    chk("rm", 20'h00032, {4'h0, remaining_capacity_value});
    chk("fcc", 20'h000C8, {4'h0, full_capacity_value});
    chk("pct", 20'h00019, {12'h0, charge_percent_value});
    wr(`GT_A_CFG, 16'h000C);
    cyc(4);
    chk("rm", 20'h00050, {4'h0, remaining_capacity_value});
    chk("fcc", 20'h000A0, {4'h0, full_capacity_value});
    chk("pct", 20'h00032, {12'h0, charge_percent_value});
    chk("fast", 20'h0, {19'h0, fast_scale_active});
    cell_voltage <= 16'h0C1C;
    cyc(4);
    chk("fast", 20'h1, {19'h0, fast_scale_active});
    nrst <= 1'b0;
    cyc(2);
    nrst <= 1'b1;
    cyc(2);
    chk("qmax_reset", 20'h003E8, {4'h0, qmax});
    rdchk("scale", `GT_A_SCALE, `GT_SCALE_FINE);
    results();
  end
endmodule : gt_core_tb
